//--- rtl/rfc_map.vh
/*
 * constants for the rfc gated measurement counter: stop-mode codes,
 * field positions and reset values.
 * assumes inclusion by bare name from rtl design files.
 */
`ifndef RFC_MAP_VH
`define RFC_MAP_VH

// =====================================================================
// stop-mode field of timer0_control
// =====================================================================
`define RFC_STOP_OFF        2'h0
`define RFC_STOP_M1         2'h1
`define RFC_STOP_M2         2'h2
`define RFC_STOP_M3         2'h3
`define RFC_STOP_MSB        7
`define RFC_STOP_LSB        6

// =====================================================================
// interrupt enable bit, reset values and timer2 stop/skip counts
// =====================================================================
`define RFC_IEF_T0_BIT      2
`define RFC_CNT_RST         24'h000000
`define RFC_T2_RST          8'h00
`define RFC_T2_STOP         8'h00
`define RFC_T2_SKIP         8'h02

`endif

//--- rtl/rfc_edge.v
/*
 * two-flop synchroniser with falling and rising edge pulses.
 * assumes input asynchronous to i_clk.
 */
`timescale 1ns/1ps
`default_nettype none

module rfc_edge (
    // clock and reset
    input  wire i_clk,
    input  wire i_rst_b,
    // raw level
    input  wire i_async,
    // synchronised outputs
    output wire o_level,
    output wire o_fall,
    output wire o_rise
);

    reg s1_q;
    reg s2_q;
    reg s3_q;

    always @(posedge i_clk) begin
        if (!i_rst_b) begin
            // idle-high pins: no false edge after reset
            s1_q <= 1'b1;
            s2_q <= 1'b1;
            s3_q <= 1'b1;
        end else begin
            s1_q <= i_async;
            s2_q <= s1_q;
            s3_q <= s2_q;
        end
    end

    assign o_level = s2_q;
    assign o_fall  = s3_q & ~s2_q;
    assign o_rise  = ~s3_q & s2_q;

endmodule

`default_nettype wire

//--- rtl/rfc_gated_counter.v
/*
 * gated measurement counter: timers 0/1/2 chained into an 8/16/24-bit
 * down-counter, gated by one of three stop modes.
 * assumes firmware loads counts and enables timers over plain ports;
 * rc_osc_input and timer2 clock are async pins, timer0_clock is a
 * same-domain enable pulse.
 */
// Functional notes
// - two-bit field selects off or modes 1-3
// - timer1 widens to 16, timer2 to 24 in mode2 only
// - timer2 counts Y-2 falls once gate opens at arm
// - timer2 zero ends; osc counts inside window
// - timer2 gate may deviate two cycles
// - measurement end raises timer0 interrupt if enabled
// - data registers hold count after modes 1,3
// - mode2: osc gates, timer0_clock clocks counter
// - mode2: first osc fall raises cycle start
// - mode2: second osc fall sets stop flag
// - mode2: full 24-bit result readable
// - mode3: timer2 not part of counter
// - mode3: two timer2 falls open/close gate
// - mode3: second timer2 fall pulses stop flag
`timescale 1ns/1ps
`default_nettype none
`include "rfc_map.vh"

module rfc_gated_counter (
    // clock and reset
    input  wire        i_clk,
    input  wire        i_rst_b,
    // configuration
    input  wire [7:0]  i_timer0_control,
    input  wire [7:0]  i_interrupt_enable_flags,
    input  wire        i_tm0_en,
    input  wire        i_tm1_en,
    input  wire        i_tm2_en,
    // load strobes
    input  wire        i_load,
    input  wire [23:0] i_load_count,
    input  wire        i_t2_load,
    input  wire [7:0]  i_t2_init,
    // clock sources
    input  wire        i_timer0_clock,
    input  wire        i_timer2_clock,
    input  wire        i_rc_osc_input,
    // status and data
    output reg  [7:0]  o_tm0_data,
    output reg  [7:0]  o_tm1_data,
    output reg  [7:0]  o_tm2_data,
    output reg         o_cycle_start_gate,
    output reg         o_measure_stop_flag,
    output reg         o_timer0_irq
);

    localparam ST_IDLE = 2'h0;
    localparam ST_ARM  = 2'h1;
    localparam ST_RUN  = 2'h2;
    localparam ST_DONE = 2'h3;

    // =================================================================
    // synchronisers
    // =================================================================
    wire osc_fall;
    wire t2_fall;

    rfc_edge u_osc (
        .i_clk   (i_clk),
        .i_rst_b (i_rst_b),
        .i_async (i_rc_osc_input),
        .o_level (),
        .o_fall  (osc_fall),
        .o_rise  ()
    );

    rfc_edge u_t2 (
        .i_clk   (i_clk),
        .i_rst_b (i_rst_b),
        .i_async (i_timer2_clock),
        .o_level (),
        .o_fall  (t2_fall),
        .o_rise  ()
    );

    // =================================================================
    // decode
    // =================================================================
    wire [1:0] mode = i_timer0_control[`RFC_STOP_MSB:`RFC_STOP_LSB];
    wire ext16 = i_tm0_en & i_tm1_en;
    wire ext24 = ext16 & i_tm2_en & (mode == `RFC_STOP_M2);
    wire armed = i_tm0_en & ((mode == `RFC_STOP_M2) | i_tm2_en);

    // down-count one step at chosen width
    function [23:0] dec_cnt;
        input [23:0] v;
        input        e16;
        input        e24;
        begin
            if (e24)
                dec_cnt = v - 24'h000001;
            else if (e16)
                dec_cnt = {v[23:16], v[15:0] - 16'h0001};
            else
                dec_cnt = {v[23:8], v[7:0] - 8'h01};
        end
    endfunction

    reg [1:0]  state_q;
    reg [23:0] cnt_q;
    reg [7:0]  t2_q;
    reg        arm_q;

    // counter clock per mode
    wire cnt_tick = (mode == `RFC_STOP_M2) ? i_timer0_clock
                                           : osc_fall;

    // =================================================================
    // control machine
    // =================================================================
    always @(posedge i_clk) begin
        if (!i_rst_b) begin
            state_q             <= ST_IDLE;
            cnt_q               <= `RFC_CNT_RST;
            t2_q                <= `RFC_T2_RST;
            arm_q               <= 1'b0;
            o_cycle_start_gate  <= 1'b0;
            o_measure_stop_flag <= 1'b0;
            o_timer0_irq        <= 1'b0;
        end else begin
            arm_q        <= armed;
            o_timer0_irq <= 1'b0;
            if (mode == `RFC_STOP_M3)
                o_measure_stop_flag <= 1'b0;
            if (i_load) begin
                cnt_q               <= i_load_count;
                state_q             <= ST_IDLE;
                o_cycle_start_gate  <= 1'b0;
                o_measure_stop_flag <= 1'b0;
            end
            if (i_t2_load)
                t2_q <= i_t2_init;
            if (!i_load) begin
                case (state_q)
                    ST_IDLE: begin
                        if (mode != `RFC_STOP_OFF && armed && !arm_q) begin
                            state_q             <= ST_ARM;
                            o_measure_stop_flag <= 1'b0;
                        end
                    end
                    ST_ARM: begin
                        if (!armed) begin
                            state_q <= ST_IDLE;
                        end else if (mode == `RFC_STOP_M1) begin
                            // gate opens now; t2 edge sampling gives
                            // up to two timer2 cycles of slip
                            o_cycle_start_gate <= 1'b1;
                            state_q            <= ST_RUN;
                            if (t2_q > `RFC_T2_SKIP)
                                t2_q <= t2_q - `RFC_T2_SKIP;
                            else
                                t2_q <= `RFC_T2_STOP;
                        end else if ((mode == `RFC_STOP_M2 && osc_fall) ||
                                     (mode == `RFC_STOP_M3 && t2_fall)) begin
                            o_cycle_start_gate <= 1'b1;
                            state_q            <= ST_RUN;
                        end
                    end
                    ST_RUN: begin
                        if (!armed) begin
                            state_q            <= ST_IDLE;
                            o_cycle_start_gate <= 1'b0;
                        end else if ((mode == `RFC_STOP_M1 &&
                                      t2_q == `RFC_T2_STOP) ||
                                     (mode == `RFC_STOP_M2 && osc_fall) ||
                                     (mode == `RFC_STOP_M3 && t2_fall)) begin
                            o_cycle_start_gate  <= 1'b0;
                            o_measure_stop_flag <= 1'b1;
                            o_timer0_irq <= i_interrupt_enable_flags
                                            [`RFC_IEF_T0_BIT];
                            state_q <= ST_DONE;
                        end else begin
                            if (mode == `RFC_STOP_M1 && t2_fall)
                                t2_q <= t2_q - 8'h01;
                            if (cnt_tick)
                                cnt_q <= dec_cnt(cnt_q, ext16, ext24);
                        end
                    end
                    ST_DONE: begin
                        // hold result until reload or re-enable
                        if (!armed)
                            state_q <= ST_IDLE;
                    end
                    default: state_q <= ST_IDLE;
                endcase
            end
        end
    end

    // =================================================================
    // readback registers
    // =================================================================
    always @(posedge i_clk) begin
        if (!i_rst_b) begin
            o_tm0_data <= 8'h00;
            o_tm1_data <= 8'h00;
            o_tm2_data <= 8'h00;
        end else begin
            o_tm0_data <= cnt_q[7:0];
            o_tm1_data <= cnt_q[15:8];
            o_tm2_data <= (mode == `RFC_STOP_M2) ? cnt_q[23:16]
                                                 : t2_q;
        end
    end

endmodule

`default_nettype wire

//--- test/rfc_chk_assertions.sv
/* checker: gate, stop, irq and count timing of rfc_gated_counter.
   assumes one clock domain, bound onto the design top. */
`timescale 1ns/1ps
`default_nettype none
`include "rfc_map.vh"
module rfc_chk (
    // clock and reset
    input wire logic       i_clk,
    input wire logic       i_rst_b,
    // watched inputs
    input wire logic       i_tm0_en,
    input wire logic       i_load,
    input wire logic       i_rc_osc_input,
    input wire logic [7:0] i_timer0_control,
    // watched outputs
    input wire logic [7:0] o_tm0_data,
    input wire logic [7:0] o_tm1_data,
    input wire logic       o_cycle_start_gate,
    input wire logic       o_measure_stop_flag,
    input wire logic       o_timer0_irq
);
// =====================================================================
// relations
default clocking @(posedge i_clk); endclocking
default disable iff (!i_rst_b);
wire       [1:0] md = i_timer0_control[7:6];
reg        [5:0] hist_q;
// recent gate and load, so a late count update is still excused
always @(posedge i_clk) hist_q <= {hist_q[3:0], o_cycle_start_gate, i_load};
sequence s_gate_end;
    o_cycle_start_gate ##1 !o_cycle_start_gate;
endsequence
a_irq_pulse: assert property (o_timer0_irq |=> !o_timer0_irq)
    else $error("irq too wide");
a_end_stop: assert property (s_gate_end |->
    ($past(o_measure_stop_flag) or ##[0:1] o_measure_stop_flag))
    else $error("gate closed, no stop");
a_gate_stop: assert property (
    !(o_cycle_start_gate && o_measure_stop_flag))
    else $error("gate and stop high");
a_stop_hold: assert property (
    o_measure_stop_flag && !i_load && i_tm0_en &&
    (md == `RFC_STOP_M1 || md == `RFC_STOP_M2) |=> o_measure_stop_flag)
    else $error("stop dropped");
a_stop_pulse: assert property (o_measure_stop_flag && md == `RFC_STOP_M3
    |=> !o_measure_stop_flag) else $error("stop not a pulse");
a_gate_arm: assert property ($rose(o_cycle_start_gate) |->
    i_tm0_en && md != `RFC_STOP_OFF) else $error("gate unarmed");
a_m2_open: assert property (
    $rose(o_cycle_start_gate) && md == `RFC_STOP_M2
    |-> !$past(i_rc_osc_input, 3)) else $error("gate not on osc fall");
a_count_gated: assert property (
    $changed({o_tm1_data, o_tm0_data}) |-> |hist_q)
    else $error("count moved ungated");
endmodule
bind rfc_gated_counter rfc_chk u_chk (.i_clk(i_clk), .i_rst_b(i_rst_b),
    .i_tm0_en(i_tm0_en), .i_load(i_load), .i_rc_osc_input(i_rc_osc_input),
    .i_timer0_control(i_timer0_control), .o_tm0_data(o_tm0_data),
    .o_tm1_data(o_tm1_data), .o_cycle_start_gate(o_cycle_start_gate),
    .o_measure_stop_flag(o_measure_stop_flag), .o_timer0_irq(o_timer0_irq));
`default_nettype wire

//--- test/rfc_osc_model.sv
/* rc sensor oscillator; also serves as the timer2 clock source.
   assumes ns units; rests high while not running. */
`timescale 1ns/1ps
`default_nettype none
module rfc_osc_model #(
    parameter integer HALF_NS = 200
) (
    input  wire logic i_run,
    output var logic  o_osc
);
// =====================================================================
// oscillation
initial o_osc = 1'h1;
always begin
    #(HALF_NS);
    o_osc = i_run ? ~o_osc : 1'h1;
end
endmodule
`default_nettype wire

//--- test/tb_top.sv
/* bench for rfc_gated_counter: all stop codes against a tick model.
   assumes osc half 200 ns, timer2 clock half 1000 ns. */
`timescale 1ns/1ps
`default_nettype none
`include "rfc_map.vh"
module tb_top;
// =====================================================================
// stimulus, model and checks
reg        i_clk = 1'h0, i_rst_b = 1'h0, i_tm0_en = 1'h0, i_tm1_en = 1'h0;
reg        i_tm2_en = 1'h0, i_load = 1'h0, i_t2_load = 1'h0, t0c = 1'h0;
reg  [7:0] ctl = 8'h00, interrupt_enable_flags = 8'h00, t2i = 8'h00;
reg [23:0] ld = 24'h000000;
wire       osc, t2c, gate, stop, irq;
wire [7:0] tm0, tm1, tm2;
integer    fail_count = 0, total_checks = 0, n_stop = 0, n_irq = 0, seed;
rfc_osc_model #(.HALF_NS(200)) u_osc (.i_run(i_rst_b), .o_osc(osc));
rfc_osc_model #(.HALF_NS(1000)) u_t2c (.i_run(i_rst_b), .o_osc(t2c));
rfc_gated_counter dut (.i_clk(i_clk), .i_rst_b(i_rst_b),
    .i_timer0_control(ctl), .i_interrupt_enable_flags(interrupt_enable_flags),
    .i_tm0_en(i_tm0_en), .i_tm1_en(i_tm1_en), .i_tm2_en(i_tm2_en),
    .i_load(i_load), .i_load_count(ld), .i_t2_load(i_t2_load),
    .i_t2_init(t2i), .i_timer0_clock(t0c), .i_timer2_clock(t2c),
    .i_rc_osc_input(osc), .o_tm0_data(tm0), .o_tm1_data(tm1),
    .o_tm2_data(tm2), .o_cycle_start_gate(gate),
    .o_measure_stop_flag(stop), .o_timer0_irq(irq));
initial forever #10 i_clk = ~i_clk;
always @(posedge i_clk) begin
    t0c <= ~t0c;
    if (stop === 1'h1) n_stop <= n_stop + 1;
    if (irq === 1'h1) n_irq <= n_irq + 1;
end
task check(input [31:0] seen, input [31:0] want);
    begin
        total_checks = total_checks + 1;
        if (seen !== want) begin
            fail_count = fail_count + 1;
            $display("Error at %0t: got %h want %h", $time, seen, want);
        end
    end
endtask
task close_out;
    begin
        $display("checks %0d errors %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    end
endtask
// en is {irq enable, timer2, timer1}; tk osc or timer0 ticks, tol slack
task run(input [1:0] m, input [2:0] en, input integer tk, input integer tol);
    integer    i, y, w, bs, bi;
    reg [23:0] st, msk, got;
    begin
        y = 4 + $urandom % 4;
        st = 24'h800000 | 24'($urandom);
        if (m == `RFC_STOP_M1) tk = (y - 2) * 5;
        msk = (m == `RFC_STOP_M2 && en[1]) ? 24'hFFFFFF
            : (en[0] ? 24'h00FFFF : 24'h0000FF);
        @(posedge i_clk);
        i_load <= 1'h1;
        ld <= st;
        i_t2_load <= 1'h1;
        t2i <= y[7:0];
        ctl <= {m, 6'h00};
        interrupt_enable_flags <= {5'h00, en[2], 2'h0};
        @(posedge i_clk);
        i_load <= 1'h0;
        i_t2_load <= 1'h0;
        i_tm1_en <= en[0];
        if (m == `RFC_STOP_M1) i_tm0_en <= 1'h1;
        else i_tm2_en <= en[1];
        @(posedge i_clk);
        if (m == `RFC_STOP_M1) i_tm2_en <= 1'h1;
        else i_tm0_en <= 1'h1;
        @(negedge i_clk);
        bs = n_stop;
        bi = n_irq;
        for (i = 0; i < 2000 && n_stop == bs; i = i + 1) @(negedge i_clk);
        repeat (4) @(negedge i_clk);
        got = {tm2, tm1, tm0} & msk;
        w = ((st & msk) - got) & msk;
        check(n_stop != bs, m != `RFC_STOP_OFF);
        check(w >= tk - tol && w <= tk + tol, 32'h1);
        check(n_irq - bi, m != `RFC_STOP_OFF && en[2]);
        if (m == `RFC_STOP_M1) check(tm2, 32'h0);
        if (m == `RFC_STOP_M3) check(tm2, y);
        repeat (20) @(negedge i_clk);
        check({tm2, tm1, tm0} & msk, got);
        @(posedge i_clk);
        i_tm0_en <= 1'h0;
        i_tm1_en <= 1'h0;
        i_tm2_en <= 1'h0;
    end
endtask
initial begin
    seed = $urandom(23);
    repeat (8) @(posedge i_clk);
    i_rst_b <= 1'h1;
    @(negedge i_clk);
    check({tm2, tm1, tm0, gate, stop, irq}, 32'h0);
    run(`RFC_STOP_M1, 3'h7, 0, 11);
    run(`RFC_STOP_M1, 3'h2, 0, 11);
    run(`RFC_STOP_M2, 3'h3, 10, 1);
    run(`RFC_STOP_M2, 3'h4, 10, 1);
    run(`RFC_STOP_M3, 3'h6, 5, 1);
    run(`RFC_STOP_M3, 3'h3, 5, 1);
    run(`RFC_STOP_OFF, 3'h7, 0, 0);
    close_out;
end
initial begin
    #400000;
    fail_count = fail_count + 1;
    close_out;
end
endmodule
`default_nettype wire
